/* File: hdl/memory_checker_pkg.sv */
// package for the memory checker block: constants, layouts, state codes
// assumes a single 25 MHz clock domain and plain control ports
//
// Notes on behaviour
// - each 16-bit word folds in one step
// - 32-bit lfsr divides block into crc
// - lfsr doubles as pseudo-random source
// - feedback polynomial is software programmable
// - block counter sets words per crc
// - finished crc compared with reference automatically
// - mismatch raises interrupt request
package memory_checker_pkg;
  // ----------------------------------------
  // sizes and reset values
  // ----------------------------------------
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned SIG_W      = 32;
  localparam int unsigned CNT_W      = 16;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam logic [SIG_W-1:0] SIG_RESET  = 32'hffff_ffff;
  localparam logic [SIG_W-1:0] POLY_RESET = 32'h04c1_1db7;
  localparam logic [CNT_W-1:0] CNT_ONE    = 16'h0001;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [SIG_W-1:0] poly;
    logic [SIG_W-1:0] seed;
    logic [SIG_W-1:0] ref_crc;
    logic [CNT_W-1:0] block_len;
  } memory_checker_cfg_type;

  typedef struct packed {
    logic             done;
    logic             err;
    logic [SIG_W-1:0] crc;
  } memory_checker_result_type;

  typedef enum logic [2:0] {
    MEMORY_CHECKER_IDLE = 3'b001,
    MEMORY_CHECKER_RUN  = 3'b010,
    MEMORY_CHECKER_RAND = 3'b100
  } memory_checker_state_type;
endpackage

/* File: hdl/memory_checker_fifo.sv */
// small synchronous fifo in front of the compression stage
// assumes both sides on mclk_in
`timescale 1ns/1ps
module memory_checker_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input  wire logic             mclk_in,
  input  wire logic             resetn_in,
  // fill side
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  // drain side
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  // pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("depth must be power of two");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_reg;
  logic [AW:0]      rd_reg;
  logic             push;
  logic             pop;
  logic [AW:0]      wr_next;
  logic [AW:0]      rd_next;

  assign out_valid_out = wr_reg != rd_reg;
  assign wr_next       = push ? wr_reg + 1'b1 : wr_reg;
  assign rd_next       = pop  ? rd_reg + 1'b1 : rd_reg;
  assign out_data_out  = mem_reg[rd_reg[AW-1:0]];
  assign push = in_valid_in && in_ready_out;
  assign pop  = out_valid_out && out_ready_in;

  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem_reg[wr_reg[AW-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      wr_reg       <= '0;
      rd_reg       <= '0;
      in_ready_out <= 1'b1;
    end else begin
      wr_reg       <= wr_next;
      rd_reg       <= rd_next;
      // ready is registered so the top-level port comes from a flop
      in_ready_out <= (wr_next - rd_next) != (AW+1)'(DEPTH);
    end
  end

  property p_ready_matches_room;
    @(posedge mclk_in) disable iff (!resetn_in)
      in_ready_out == ((wr_reg - rd_reg) != (AW+1)'(DEPTH));
  endproperty
  a_ready_matches_room: assert property (p_ready_matches_room) else $error("ready out of step");
endmodule

/* File: hdl/memory_checker_core.sv */
// memory checker: 32-bit crc signature, 16 bits in parallel, over blocks of words
// assumes words arrive from logic on mclk_in; config held stable per block
`timescale 1ns/1ps
module memory_checker_core #(
  parameter int unsigned CNT_W = memory_checker_pkg::CNT_W
) (
  // clock and reset
  input  wire logic                        mclk_in,
  input  wire logic                        resetn_in,
  // configuration
  input  wire memory_checker_pkg::memory_checker_cfg_type      cfg_in,
  input  wire logic                        enable_in,
  input  wire logic                        rand_mode_in,
  input  wire logic                        restart_in,
  input  wire logic                        err_clear_in,
  // data stream
  input  wire logic                        data_valid_in,
  input  wire logic [memory_checker_pkg::DATA_W-1:0] data_in,
  output logic                             data_ready_out,
  // results
  output memory_checker_pkg::memory_checker_result_type        result_out,
  output logic [memory_checker_pkg::SIG_W-1:0]       signature_out,
  output logic                             err_sticky_out,
  output logic                             irq_out,
  output logic [CNT_W-1:0]                 words_left_out
);
  if (CNT_W < 1 || CNT_W > memory_checker_pkg::CNT_W) begin : g_bad_cnt_w
    $error("bad counter width");
  end

  // ----------------------------------------
  // one compression step over a full word
  // ----------------------------------------
  function automatic logic [memory_checker_pkg::SIG_W-1:0] fold(
    input logic [memory_checker_pkg::SIG_W-1:0]  sig,
    input logic [memory_checker_pkg::SIG_W-1:0]  poly,
    input logic [memory_checker_pkg::DATA_W-1:0] word
  );
    logic [memory_checker_pkg::SIG_W-1:0] s;
    logic                       fb;
    s = sig;
    for (int i = memory_checker_pkg::DATA_W - 1; i >= 0; i--) begin
      fb = s[memory_checker_pkg::SIG_W-1] ^ word[i];
      s  = {s[memory_checker_pkg::SIG_W-2:0], 1'b0} ^ (fb ? poly : '0);
    end
    return s;
  endfunction

  // ----------------------------------------
  // input buffer
  // ----------------------------------------
  logic                        fifo_valid;
  logic [memory_checker_pkg::DATA_W-1:0] fifo_data;
  logic                        take;

  memory_checker_fifo #(
    .WIDTH(memory_checker_pkg::DATA_W),
    .DEPTH(memory_checker_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk_in      (mclk_in),
    .resetn_in    (resetn_in),
    .in_valid_in  (data_valid_in),
    .in_data_in   (data_in),
    .in_ready_out (data_ready_out),
    .out_valid_out(fifo_valid),
    .out_data_out (fifo_data),
    .out_ready_in (take)
  );

  // ----------------------------------------
  // state
  // ----------------------------------------
  memory_checker_pkg::memory_checker_state_type    state_reg;
  memory_checker_pkg::memory_checker_state_type    state_next;
  logic [memory_checker_pkg::SIG_W-1:0]  sig_reg;
  logic [memory_checker_pkg::SIG_W-1:0]  sig_next;
  logic [CNT_W-1:0]            cnt_reg;
  logic                        last_word;
  logic                        mismatch;

  localparam logic [CNT_W-1:0] CNT_ONE_W = CNT_W'(memory_checker_pkg::CNT_ONE);

  // the buffer only drains while a block runs, so a stalled checker
  // pushes back on the source instead of dropping words
  assign take      = (state_reg == memory_checker_pkg::MEMORY_CHECKER_RUN) && fifo_valid;
  assign sig_next  = fold(sig_reg, cfg_in.poly, fifo_data);
  assign last_word = take && (cnt_reg == CNT_ONE_W);
  assign mismatch  = sig_next != cfg_in.ref_crc;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      memory_checker_pkg::MEMORY_CHECKER_IDLE: begin
        if (enable_in) state_next = rand_mode_in ? memory_checker_pkg::MEMORY_CHECKER_RAND : memory_checker_pkg::MEMORY_CHECKER_RUN;
      end
      memory_checker_pkg::MEMORY_CHECKER_RUN: begin
        if (!enable_in || rand_mode_in) state_next = memory_checker_pkg::MEMORY_CHECKER_IDLE;
      end
      memory_checker_pkg::MEMORY_CHECKER_RAND: begin
        if (!enable_in || !rand_mode_in) state_next = memory_checker_pkg::MEMORY_CHECKER_IDLE;
      end
      default: state_next = memory_checker_pkg::MEMORY_CHECKER_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) state_reg <= memory_checker_pkg::MEMORY_CHECKER_IDLE;
    else            state_reg <= state_next;
  end

  // ----------------------------------------
  // signature register
  // ----------------------------------------
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      sig_reg <= memory_checker_pkg::SIG_RESET;
    end else if (restart_in || state_reg == memory_checker_pkg::MEMORY_CHECKER_IDLE) begin
      sig_reg <= cfg_in.seed;
    end else if (state_reg == memory_checker_pkg::MEMORY_CHECKER_RAND) begin
      // free-running lfsr with zero input gives the random sequence
      sig_reg <= fold(sig_reg, cfg_in.poly, '0);
    end else if (last_word) begin
      sig_reg <= cfg_in.seed;
    end else if (take) begin
      sig_reg <= sig_next;
    end
  end

  // ----------------------------------------
  // block counter
  // ----------------------------------------
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      cnt_reg <= CNT_ONE_W;
    end else if (restart_in || state_reg == memory_checker_pkg::MEMORY_CHECKER_IDLE || last_word) begin
      // a length of zero is treated as one word per block
      cnt_reg <= (cfg_in.block_len[CNT_W-1:0] == '0) ? CNT_ONE_W
                                                      : cfg_in.block_len[CNT_W-1:0];
    end else if (take) begin
      cnt_reg <= cnt_reg - CNT_ONE_W;
    end
  end

  // ----------------------------------------
  // results, compare and error
  // ----------------------------------------
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      result_out <= '0;
    end else begin
      result_out.done <= last_word;
      if (last_word) begin
        result_out.crc <= sig_next;
        result_out.err <= mismatch;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      err_sticky_out <= 1'b0;
    end else if (last_word && mismatch) begin
      err_sticky_out <= 1'b1;
    end else if (err_clear_in) begin
      err_sticky_out <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) irq_out <= 1'b0;
    else            irq_out <= last_word && mismatch;
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      signature_out  <= memory_checker_pkg::SIG_RESET;
      words_left_out <= '0;
    end else begin
      signature_out  <= sig_reg;
      words_left_out <= cnt_reg;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_irq_on_mismatch;
    @(posedge mclk_in) disable iff (!resetn_in)
      (last_word && mismatch) |=> irq_out && err_sticky_out && result_out.err;
  endproperty
  a_irq_on_mismatch: assert property (p_irq_on_mismatch) else $error("irq missing");

  property p_no_irq_on_match;
    @(posedge mclk_in) disable iff (!resetn_in)
      !(last_word && mismatch) |=> !irq_out;
  endproperty
  a_no_irq_on_match: assert property (p_no_irq_on_match) else $error("spurious irq");

  property p_crc_captured;
    @(posedge mclk_in) disable iff (!resetn_in)
      last_word |=> result_out.done && result_out.crc == $past(sig_next);
  endproperty
  a_crc_captured: assert property (p_crc_captured) else $error("crc not captured");

  property p_fold_step;
    @(posedge mclk_in) disable iff (!resetn_in || restart_in)
      (take && !last_word) |=> sig_reg == $past(sig_next);
  endproperty
  a_fold_step: assert property (p_fold_step) else $error("word not folded");

  property p_count_down;
    @(posedge mclk_in) disable iff (!resetn_in || restart_in)
      (take && !last_word) |=> cnt_reg == $past(cnt_reg) - CNT_ONE_W;
  endproperty
  a_count_down: assert property (p_count_down) else $error("counter stuck");

  property p_reload;
    @(posedge mclk_in) disable iff (!resetn_in)
      last_word |=> cnt_reg != '0 && sig_reg == $past(cfg_in.seed);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload");

  property p_sticky;
    @(posedge mclk_in) disable iff (!resetn_in)
      (err_sticky_out && !err_clear_in) |=> err_sticky_out;
  endproperty
  a_sticky: assert property (p_sticky) else $error("error flag lost");

  property p_rand_moves;
    @(posedge mclk_in) disable iff (!resetn_in || restart_in)
      (state_reg == memory_checker_pkg::MEMORY_CHECKER_RAND) |=> sig_reg == fold($past(sig_reg), $past(cfg_in.poly), '0);
  endproperty
  a_rand_moves: assert property (p_rand_moves) else $error("lfsr not stepping");
endmodule

/* File: bench/memory_checker_core_bench.sv */
// bench for the memory checker core: random crc blocks, fifo fill, prbs mode
// assumes words wait in the fifo while the core is not enabled
`timescale 1ns/1ps
module memory_checker_core_bench;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic                      mclk_in = 1'b0;
  logic                      resetn_in = 1'b0;
  memory_checker_pkg::memory_checker_cfg_type    cfg_in;
  logic                      enable_in = 1'b0;
  logic                      rand_mode_in = 1'b0;
  logic                      restart_in = 1'b0;
  logic                      err_clear_in = 1'b0;
  logic                      data_valid_in = 1'b0;
  logic [15:0]               data_in = 16'h0000;
  logic                      data_ready_out;
  memory_checker_pkg::memory_checker_result_type result_out;
  logic [31:0]               signature_out;
  logic                      err_sticky_out;
  logic                      irq_out;
  logic [15:0]               words_left_out;
  int                        err_count = 0;
  int                        samples_checked = 0;
  logic                      sticky_exp = 1'b0;

  always #20 mclk_in = ~mclk_in;

  memory_checker_core memory_checker_core_inst (
    .mclk_in        (mclk_in),
    .resetn_in      (resetn_in),
    .cfg_in         (cfg_in),
    .enable_in      (enable_in),
    .rand_mode_in   (rand_mode_in),
    .restart_in     (restart_in),
    .err_clear_in   (err_clear_in),
    .data_valid_in  (data_valid_in),
    .data_in        (data_in),
    .data_ready_out (data_ready_out),
    .result_out     (result_out),
    .signature_out  (signature_out),
    .err_sticky_out (err_sticky_out),
    .irq_out        (irq_out),
    .words_left_out (words_left_out)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // msb first, non-reflected, one whole word per call
  function automatic logic [31:0] fold(input logic [31:0] s, input logic [31:0] p,
                                       input logic [15:0] w);
    logic fb;
    for (int i = 15; i >= 0; i--) begin
      fb = s[31] ^ w[i];
      s  = {s[30:0], 1'b0} ^ (fb ? p : 32'h0000_0000);
    end
    return s;
  endfunction

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // valid stays up afterwards so back-to-back words need no gap
  task automatic push(input logic [15:0] w);
    int n;
    data_valid_in <= 1'b1;
    data_in       <= w;
    for (n = 0; n < 50; n++) begin
      @(negedge mclk_in);
      if (data_ready_out === 1'b1) break;
    end
    if (n == 50) begin
      err_count++;
      complete_run();
    end
    @(posedge mclk_in);
  endtask

  task automatic run_block(input logic [15:0] len, input bit good, input bit pre,
                           input bit abort = 1'b0);
    logic [31:0] p;
    logic [31:0] s;
    logic [31:0] sig;
    logic [15:0] wq[$];
    int          n;
    p   = $urandom | 32'h0000_0001;
    s   = $urandom;
    sig = s;
    for (int i = 0; i < ((len == 16'h0000) ? 1 : len); i++) begin
      wq.push_back(16'($urandom));
      sig = fold(sig, p, wq[i]);
    end
    cfg_in    <= '{p, s, good ? sig : sig ^ 32'h0000_0001, len};
    enable_in <= 1'b0;
    @(posedge mclk_in);
    if (pre) begin
      foreach (wq[i]) push(wq[i]);
      data_valid_in <= 1'b0;
      @(negedge mclk_in);
      check(data_ready_out, 32'h0000_0000);
      @(posedge mclk_in);
    end
    enable_in <= 1'b1;
    @(posedge mclk_in);
    if (!pre) begin
      if (abort) begin
        // a junk word is taken on the same edge as restart, which wins and reloads seed and count
        push(16'h5a5a);
        data_valid_in <= 1'b0;
        restart_in    <= 1'b1;
        @(posedge mclk_in);
        restart_in    <= 1'b0;
      end
      foreach (wq[i]) push(wq[i]);
      data_valid_in <= 1'b0;
    end
    for (n = 0; n < 100; n++) begin
      @(negedge mclk_in);
      if (result_out.done === 1'b1) break;
    end
    if (n == 100) begin
      err_count++;
      complete_run();
    end
    sticky_exp = sticky_exp | !good;
    check(result_out.crc, sig);
    check(result_out.err, !good);
    check(irq_out, !good);
    check(err_sticky_out, sticky_exp);
    // the lfsr is already reloaded; the finished crc stays in result_out
    @(negedge mclk_in);
    check(signature_out, s);
    check(words_left_out, (len == 16'h0000) ? 32'h0000_0001 : 32'(len));
    check(result_out.done, 32'h0000_0000);
    check(irq_out, 32'h0000_0000);
    @(posedge mclk_in);
    $display("block of %0d words done", len);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] x;
    int          k;
    cfg_in = '{memory_checker_pkg::POLY_RESET, memory_checker_pkg::SIG_RESET, 32'h0000_0000, 16'h0001};
    void'($urandom(16));
    repeat (2) @(posedge mclk_in);
    resetn_in <= 1'b1;
    @(negedge mclk_in);
    check(signature_out, memory_checker_pkg::SIG_RESET);
    check(err_sticky_out, 32'h0000_0000);
    check(data_ready_out, 32'h0000_0001);
    $display("reset test done");
    @(posedge mclk_in);
    run_block(16'h0000, 1'b1, 1'b0);
    run_block(16'h0001, 1'b0, 1'b0);
    run_block(16'h0008, 1'b1, 1'b1);
    repeat (8) run_block(16'($urandom % 6 + 1), 1'($urandom % 2), 1'b0);
    err_clear_in <= 1'b1;
    @(posedge mclk_in);
    err_clear_in <= 1'b0;
    sticky_exp = 1'b0;
    @(negedge mclk_in);
    check(err_sticky_out, 32'h0000_0000);
    $display("error clear test done");
    @(posedge mclk_in);
    run_block(16'h0003, 1'b1, 1'b0);
    run_block(16'h0004, 1'b0, 1'b0, 1'b1);
    // prbs: leave idle, then each cycle folds a zero word
    x         = 32'h1234_5678;
    cfg_in    <= '{memory_checker_pkg::POLY_RESET, x, 32'h0000_0000, 16'h0001};
    enable_in <= 1'b0;
    @(posedge mclk_in);
    enable_in    <= 1'b1;
    rand_mode_in <= 1'b1;
    for (k = 0; k < 10; k++) begin
      @(negedge mclk_in);
      if (signature_out === x) break;
    end
    if (k == 10) begin
      err_count++;
      complete_run();
    end
    for (k = 0; k < 5; k++) begin
      @(negedge mclk_in);
      x = fold(x, memory_checker_pkg::POLY_RESET, 16'h0000);
      check(signature_out, x);
    end
    $display("random mode test done");
    complete_run();
  end
endmodule
